// File: ufi_map.svh
`ifndef UFI_MAP_SVH
`define UFI_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (each writable one has CLR/SET/INV aliases at +4/+8/+C)
// ----------------------------------------------------------------
`define UFI_OFF_OTG_IE      3'h0
`define UFI_OFF_OTG_FLAGS   3'h1
`define UFI_OFF_USB_FLAGS   3'h2
`define UFI_OFF_USB_IE      3'h3
`define UFI_OFF_ERR_EN      3'h4
`define UFI_OFF_ERR_FLAGS   3'h5
`define UFI_OFF_XFER_STAT   3'h6
`define UFI_OFF_CTRL        3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UFI_B_ID            7
`define UFI_B_TIMER         6
`define UFI_B_LINE          5
`define UFI_B_ACTV          4
`define UFI_B_SESSVD        3
`define UFI_B_SESSEND       2
`define UFI_B_VBUSVD        0
`define UFI_B_STALL         7
`define UFI_B_ATTACH        6
`define UFI_B_RESUME        5
`define UFI_B_IDLE          4
`define UFI_B_TOKEN         3
`define UFI_B_SOF           2
`define UFI_B_ERRSUM        1
`define UFI_B_RST_DET       0
`define UFI_B_HOST_EN       0

// ----------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------
`define UFI_MASK_FD         8'hFD
`define UFI_MASK_CTRL       8'h01
`define UFI_RST_REG         8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UFI_CLK_PERIOD_NS   25
`define UFI_T_LINE_NS       2500
`define UFI_T_IDLE_NS       3000000
`define UFI_T_MS_NS         1000000
`define UFI_CYC_LINE  ((`UFI_T_LINE_NS + `UFI_CLK_PERIOD_NS - 1) / `UFI_CLK_PERIOD_NS)
`define UFI_CYC_IDLE  ((`UFI_T_IDLE_NS + `UFI_CLK_PERIOD_NS - 1) / `UFI_CLK_PERIOD_NS)
`define UFI_CYC_MS    (`UFI_T_MS_NS / `UFI_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Transfer status queue
// ----------------------------------------------------------------
`define UFI_STAT_DEPTH      4

`endif

// File: ufi_pkg.sv
`default_nettype none

package ufi_pkg;

    // ------------------------------------------------------------
    // Write alias selected by address bits 3:2
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UFI_AL_REG = 2'h0,
        UFI_AL_CLR = 2'h1,
        UFI_AL_SET = 2'h2,
        UFI_AL_INV = 2'h3
    } ufi_alias_e;

    // ------------------------------------------------------------
    // Line class of the synchronised data lines, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        UFI_LN_SE0 = 4'h1,
        UFI_LN_J   = 4'h2,
        UFI_LN_K   = 4'h4,
        UFI_LN_SE1 = 4'h8
    } ufi_line_e;

    // ------------------------------------------------------------
    // Event strobes from the protocol engine
    // ------------------------------------------------------------
    typedef struct packed {
        logic       stall_rx;
        logic       stall_tx;
        logic       sof_rx;
        logic       sof_thresh;
        logic       token_done;
        logic [7:0] token_stat;
        logic [7:0] err;
    } ufi_evt_s;

    // ------------------------------------------------------------
    // OTG comparator and ID pins
    // ------------------------------------------------------------
    typedef struct packed {
        logic id;
        logic vbus_valid;
        logic sess_valid;
        logic sess_end;
    } ufi_otg_s;

endpackage

`default_nettype wire

// File: ufi_irq_flags.sv
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`include "ufi_map.svh"
`default_nettype none

module ufi_irq_flags
    import ufi_pkg::*;
#(
    parameter int unsigned IDLE_CYC = `UFI_CYC_IDLE,
    parameter int unsigned MS_CYC   = `UFI_CYC_MS
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Protocol engine events
    input  wire ufi_evt_s    evt,
    output var  logic        token_ready,
    // Bus and OTG pins
    input  wire logic        line_dp,
    input  wire logic        line_dm,
    input  wire ufi_otg_s    otg_pins,
    // Interrupt request
    output var  logic        irq
);

    // ------------------------------------------------------------
    // Alias write helper
    // ------------------------------------------------------------
    function automatic logic [7:0] apply_wr(input logic [7:0] old, input logic [7:0] wd,
                                            input ufi_alias_e al, input logic w1c);
        unique case (al)
            UFI_AL_REG: apply_wr = w1c ? (old & ~wd) : wd;
            UFI_AL_CLR: apply_wr = old & ~wd;
            UFI_AL_SET: apply_wr = old | wd;
            UFI_AL_INV: apply_wr = old ^ wd;
        endcase
    endfunction

    localparam logic [16:0] CYC_LINE = 17'(`UFI_CYC_LINE);
    localparam logic [16:0] CYC_IDLE = 17'(IDLE_CYC);
    localparam logic [16:0] CYC_MS   = 17'(MS_CYC);
    localparam logic [2:0]  DEPTH    = 3'(`UFI_STAT_DEPTH);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] pin_meta_q;
    logic [5:0] pin_sync_q;
    logic [5:0] pin_prev_q;

    // Two flops per pin, then an edge reference
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_q <= 6'h00;
            pin_sync_q <= 6'h00;
            pin_prev_q <= 6'h00;
        end else begin
            pin_meta_q <= {line_dp, line_dm, otg_pins};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    logic      dp_s;
    logic      dm_s;
    logic      line_chg;
    ufi_line_e line_cls;
    logic [3:0] otg_chg;

    // Line class and change strobes
    always_comb begin
        dp_s     = pin_sync_q[5];
        dm_s     = pin_sync_q[4];
        line_chg = pin_sync_q[5:4] != pin_prev_q[5:4];
        otg_chg  = pin_sync_q[3:0] ^ pin_prev_q[3:0];
        unique case ({dp_s, dm_s})
            2'b00:   line_cls = UFI_LN_SE0;
            2'b10:   line_cls = UFI_LN_J;
            2'b01:   line_cls = UFI_LN_K;
            default: line_cls = UFI_LN_SE1;
        endcase
    end

    // ------------------------------------------------------------
    // Line monitor: stable counter, attach state, ms timer
    // ------------------------------------------------------------
    logic [16:0] stable_q, stable_d;
    logic [16:0] ms_q, ms_d;
    logic        attached_q, attached_d;
    logic        ev_attach, ev_detach, ev_reset, ev_resume, ev_idle, ev_line, ev_ms;
    logic        host_en;
    logic        quiet_hit;

    // Counts cycles since the last line change and derives bus events
    always_comb begin
        stable_d   = line_chg ? 17'h00000 :
                     (stable_q == 17'h1FFFF) ? stable_q : stable_q + 17'h00001;
        quiet_hit  = !line_chg && (stable_q == CYC_LINE - 17'h00001);
        ev_line    = quiet_hit;
        ev_resume  = quiet_hit && (line_cls == UFI_LN_K);
        ev_idle    = !line_chg && (line_cls == UFI_LN_J)
                     && (stable_q == CYC_IDLE - 17'h00001);
        ev_attach  = quiet_hit && host_en && !attached_q
                     && (line_cls != UFI_LN_SE0);
        ev_detach  = quiet_hit && host_en && attached_q
                     && (line_cls == UFI_LN_SE0);
        ev_reset   = quiet_hit && !host_en && (line_cls == UFI_LN_SE0);
        attached_d = !host_en ? 1'b0 :
                     ev_attach ? 1'b1 : ev_detach ? 1'b0 : attached_q;
        ev_ms      = (ms_q == CYC_MS - 17'h00001);
        ms_d       = ev_ms ? 17'h00000 : ms_q + 17'h00001;
    end

    // Registers the line monitor
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stable_q   <= 17'h00000;
            ms_q       <= 17'h00000;
            attached_q <= 1'b0;
        end else begin
            stable_q   <= stable_d;
            ms_q       <= ms_d;
            attached_q <= attached_d;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------
    logic        awready_q, awready_d, wready_q, wready_d;
    logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [11:0] aw_addr_q, aw_addr_d;
    logic [7:0]  w_data_q, w_data_d;
    logic        w_lane_q, w_lane_d;
    logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        do_wr, wr_hit;
    logic [2:0]  wr_idx;
    ufi_alias_e  wr_al;
    logic [7:0]  rd_byte;
    logic        rd_hit;

    // Storage registers
    logic [7:0] otg_ie_q, otg_ie_d, otg_fl_q, otg_fl_d;
    logic [7:0] usb_fl_q, usb_fl_d, usb_ie_q, usb_ie_d;
    logic [7:0] err_en_q, err_en_d, err_fl_q, err_fl_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] usb_view;
    logic       irq_q, irq_d;
    logic [7:0] stat_mem_q [`UFI_STAT_DEPTH];
    logic [7:0] stat_mem_d [`UFI_STAT_DEPTH];
    logic [1:0] rd_ptr_q, rd_ptr_d, wr_ptr_q, wr_ptr_d;
    logic [2:0] cnt_q, cnt_d;
    logic       tok_ready_q, tok_ready_d;

    // Read view of a register index; upper bits stay zero
    always_comb begin
        rd_hit  = s_axi_araddr[11:7] == 5'h00;
        rd_byte = 8'h00;
        unique case (s_axi_araddr[6:4])
            `UFI_OFF_OTG_IE:    rd_byte = otg_ie_q & `UFI_MASK_FD;
            `UFI_OFF_OTG_FLAGS: rd_byte = otg_fl_q;
            `UFI_OFF_USB_FLAGS: rd_byte = usb_view;
            `UFI_OFF_USB_IE:    rd_byte = usb_ie_q;
            `UFI_OFF_ERR_EN:    rd_byte = err_en_q;
            `UFI_OFF_ERR_FLAGS: rd_byte = err_fl_q;
            `UFI_OFF_XFER_STAT: rd_byte = stat_mem_q[rd_ptr_q];
            `UFI_OFF_CTRL:      rd_byte = ctrl_q;
        endcase
    end

    // Channel handshakes: one write and one read at a time
    always_comb begin
        awready_d = awready_q;
        wready_d  = wready_q;
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        aw_addr_d = aw_addr_q;
        w_data_d  = w_data_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (s_axi_awvalid && awready_q) begin
            aw_hold_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
            awready_d = 1'b0;
        end
        if (s_axi_wvalid && wready_q) begin
            w_hold_d = 1'b1;
            w_data_d = s_axi_wdata[7:0];
            w_lane_d = s_axi_wstrb[0];
            wready_d = 1'b0;
        end
        do_wr = aw_hold_q && w_hold_q && !bvalid_q;
        if (do_wr) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (aw_addr_q[11:7] == 5'h00) ? 2'h0 : 2'h2;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d  = 1'b0;
            awready_d = 1'b1;
            wready_d  = 1'b1;
        end
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rdata_d   = {24'h000000, rd_byte};
            rresp_d   = rd_hit ? 2'h0 : 2'h2;
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
    end

    // Registers the bus slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'h0;
            rdata_q   <= 32'h00000000;
        end else begin
            awready_q <= awready_d;
            wready_q  <= wready_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            aw_addr_q <= aw_addr_d;
            w_data_q  <= w_data_d;
            w_lane_q  <= w_lane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Register file, flags and status queue
    // ------------------------------------------------------------
    logic [7:0] usb_set, otg_set, usb_sw;
    logic       tok_clr, tok_push, tok_pop, err_sum;

    // Software writes first, then hardware sets win over clears
    always_comb begin
        host_en  = ctrl_q[`UFI_B_HOST_EN];
        wr_hit   = do_wr && w_lane_q && (aw_addr_q[11:7] == 5'h00);
        wr_idx   = aw_addr_q[6:4];
        wr_al    = ufi_alias_e'(aw_addr_q[3:2]);
        err_sum  = |(err_fl_q & err_en_q);
        usb_view = {usb_fl_q[7:2], err_sum, usb_fl_q[0]};
        otg_ie_d = otg_ie_q;
        otg_fl_d = otg_fl_q;
        usb_sw   = usb_fl_q;
        usb_ie_d = usb_ie_q;
        err_en_d = err_en_q;
        err_fl_d = err_fl_q;
        ctrl_d   = ctrl_q;
        if (wr_hit) begin
            unique case (wr_idx)
                `UFI_OFF_OTG_IE:    otg_ie_d = apply_wr(otg_ie_q, w_data_q, wr_al, 1'b0)
                                               & `UFI_MASK_FD;
                `UFI_OFF_OTG_FLAGS: otg_fl_d = apply_wr(otg_fl_q, w_data_q, wr_al, 1'b1)
                                               & `UFI_MASK_FD;
                `UFI_OFF_USB_FLAGS: usb_sw   = apply_wr(usb_fl_q, w_data_q, wr_al, 1'b1)
                                               & `UFI_MASK_FD;
                `UFI_OFF_USB_IE:    usb_ie_d = apply_wr(usb_ie_q, w_data_q, wr_al, 1'b0);
                `UFI_OFF_ERR_EN:    err_en_d = apply_wr(err_en_q, w_data_q, wr_al, 1'b0);
                `UFI_OFF_ERR_FLAGS: err_fl_d = apply_wr(err_fl_q, w_data_q, wr_al, 1'b1);
                `UFI_OFF_XFER_STAT: ctrl_d   = ctrl_q;
                `UFI_OFF_CTRL:      ctrl_d   = apply_wr(ctrl_q, w_data_q, wr_al, 1'b0)
                                               & `UFI_MASK_CTRL;
            endcase
        end
        tok_clr  = usb_fl_q[`UFI_B_TOKEN] && !usb_sw[`UFI_B_TOKEN];
        tok_pop  = tok_clr && (cnt_q != 3'h0);
        tok_push = evt.token_done && (cnt_q != DEPTH);
        otg_set  = 8'h00;
        otg_set[`UFI_B_ID]      = otg_chg[3];
        otg_set[`UFI_B_TIMER]   = ev_ms;
        otg_set[`UFI_B_LINE]    = ev_line;
        otg_set[`UFI_B_ACTV]    = line_chg;
        otg_set[`UFI_B_SESSVD]  = otg_chg[1];
        otg_set[`UFI_B_SESSEND] = otg_chg[0];
        otg_set[`UFI_B_VBUSVD]  = otg_chg[2];
        usb_set  = 8'h00;
        usb_set[`UFI_B_STALL]   = host_en ? evt.stall_rx : evt.stall_tx;
        usb_set[`UFI_B_ATTACH]  = ev_attach;
        usb_set[`UFI_B_RESUME]  = ev_resume;
        usb_set[`UFI_B_IDLE]    = ev_idle;
        usb_set[`UFI_B_TOKEN]   = evt.token_done || (tok_clr && cnt_q > 3'h1);
        usb_set[`UFI_B_SOF]     = host_en ? evt.sof_thresh : evt.sof_rx;
        usb_set[`UFI_B_RST_DET] = ev_reset || ev_detach;
        usb_fl_d = (usb_sw | usb_set) & `UFI_MASK_FD;
        otg_fl_d = otg_fl_d | otg_set;
        err_fl_d = err_fl_d | evt.err;
        irq_d    = |(otg_fl_q & otg_ie_q) | |(usb_view & usb_ie_q);
    end

    // Transfer status queue pointers and storage
    always_comb begin
        stat_mem_d = stat_mem_q;
        wr_ptr_d   = wr_ptr_q;
        rd_ptr_d   = rd_ptr_q;
        if (tok_push) begin
            stat_mem_d[wr_ptr_q] = evt.token_stat;
            wr_ptr_d             = wr_ptr_q + 2'h1;
        end
        if (tok_pop) begin
            rd_ptr_d = rd_ptr_q + 2'h1;
        end
        cnt_d       = cnt_q + {2'h0, tok_push} - {2'h0, tok_pop};
        tok_ready_d = cnt_d != DEPTH;
    end

    // Registers the register file and queue
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            otg_ie_q    <= `UFI_RST_REG;
            otg_fl_q    <= `UFI_RST_REG;
            usb_fl_q    <= `UFI_RST_REG;
            usb_ie_q    <= `UFI_RST_REG;
            err_en_q    <= `UFI_RST_REG;
            err_fl_q    <= `UFI_RST_REG;
            ctrl_q      <= `UFI_RST_REG;
            irq_q       <= 1'b0;
            wr_ptr_q    <= 2'h0;
            rd_ptr_q    <= 2'h0;
            cnt_q       <= 3'h0;
            tok_ready_q <= 1'b0;
            for (int i = 0; i < `UFI_STAT_DEPTH; i++) begin
                stat_mem_q[i] <= 8'h00;
            end
        end else begin
            otg_ie_q    <= otg_ie_d;
            otg_fl_q    <= otg_fl_d;
            usb_fl_q    <= usb_fl_d;
            usb_ie_q    <= usb_ie_d;
            err_en_q    <= err_en_d;
            err_fl_q    <= err_fl_d;
            ctrl_q      <= ctrl_d;
            irq_q       <= irq_d;
            wr_ptr_q    <= wr_ptr_d;
            rd_ptr_q    <= rd_ptr_d;
            cnt_q       <= cnt_d;
            tok_ready_q <= tok_ready_d;
            stat_mem_q  <= stat_mem_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign token_ready   = tok_ready_q;
    assign irq           = irq_q;

endmodule

`default_nettype wire

// File: ufi_irq_flags_checker.sv
`default_nettype none
// ----------------------------------------
// Register bus answer checks
// ----------------------------------------
module ufi_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write side
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read side
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [11:0] aw_q;
    logic [11:0] ar_q;
    // Addresses of the accesses in flight
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
        if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    end
    wr_ans_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> !s_axi_awready ##1 (s_axi_bvalid && !s_axi_awready))
            else $error("write not answered");
    rd_ans_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
            else $error("read not answered");
    b_done_a:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
            else $error("write not closed");
    r_done_a:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
            else $error("read not closed");
    b_resp_a:
        assert property (s_axi_bvalid |-> s_axi_bresp == {aw_q[11:7] != 5'h00, 1'h0})
            else $error("bad write response");
    r_resp_a:
        assert property (s_axi_rvalid |-> s_axi_rresp == {ar_q[11:7] != 5'h00, 1'h0})
            else $error("bad read response");
    hi_zero_a:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
            else $error("upper bits set");
    ie_bit1_a:
        assert property (s_axi_rvalid && ar_q[11:4] == 8'h00 |-> !s_axi_rdata[1])
            else $error("enable bit 1 set");
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property (s_axi_rvalid && s_axi_rdata[3]);
    cover property ($rose(irq));
endmodule

bind ufi_irq_flags ufi_chk chk_u (.*);
`default_nettype wire

// File: ufi_line_model.sv
`default_nettype none
// ----------------------------------------
// Far side of the bus lines
// ----------------------------------------
module ufi_line_model
    import ufi_pkg::*;
(
    // Commanded bus state
    input  wire ufi_line_e ln,
    // Data lines
    output var  logic      dp,
    output var  logic      dm
);
    timeunit 1ns;
    timeprecision 1ps;
    // J pulls D+ up, K pulls D- up, SE0 leaves both to the pull-downs
    always_comb begin
        dp = (ln == UFI_LN_J);
        dm = (ln == UFI_LN_K);
    end
endmodule
`default_nettype wire

// File: usb_otg_interrupt_flags_test.sv
`default_nettype none
// ----------------------------------------
// Register level test of the flag block
// ----------------------------------------
module usb_otg_interrupt_flags_test
    import ufi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, token_ready, line_dp, line_dm, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    ufi_evt_s    evt;
    ufi_otg_s    otg_pins;
    ufi_line_e   ln;
    int          err_count, tests_run;
    logic [11:0] wa [5] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h000};
    logic [7:0]  wd [5] = '{8'hFF, 8'h80, 8'h02, 8'h0F, 8'h00};
    logic [7:0]  we [5] = '{8'hFD, 8'h7D, 8'h7D, 8'h70, 8'h00};
    int          ob [7] = '{7, 6, 5, 4, 3, 2, 0};
    // Bus clock
    initial aclk = 1'h0;
    always #12.5 aclk = ~aclk;
    ufi_irq_flags #(.IDLE_CYC(300), .MS_CYC(200)) dut_u (.*);
    ufi_line_model pin_u (.ln(ln), .dp(line_dp), .dm(line_dm));
    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    // Register bus master
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask
    // Engine strobes and bus line states
    task automatic pulse(input ufi_evt_s e);
        evt <= e;
        @(posedge aclk);
        evt <= '0;
        @(posedge aclk);
    endtask
    task automatic line(input ufi_line_e l, input int n);
        ln <= l;
        repeat (n) @(posedge aclk);
    endtask
    task automatic stop_test;
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        aresetn = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        evt = '0;
        otg_pins = '0;
        ln = UFI_LN_J;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        rd(12'h020, rv);
        chk(rv, 32'h0);
        chk({31'h0, token_ready}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            wr(wa[i], {24'hFFFFFF, wd[i]});
            rd(12'h000, rv);
            chk(rv, {24'h0, we[i]});
        end
        wr(12'h080, 32'h1);
        chk({30'h0, resp}, 32'h2);
        for (int i = 0; i < 7; i++) begin
            wr(12'h010, 32'hFF);
            otg_pins <= ~otg_pins;
            line((ln == UFI_LN_K) ? UFI_LN_J : UFI_LN_K, 210);
            wr(12'h000, 32'h1 << ob[i]);
            irq_is(1'h1);
            wr(12'h004, 32'hFF);
            irq_is(1'h0);
        end
        line(UFI_LN_J, 4);
        wr(12'h020, 32'hFF);
        line(UFI_LN_K, 120);
        line(UFI_LN_SE0, 120);
        line(UFI_LN_J, 320);
        rd(12'h020, rv);
        chk(rv & 32'h31, 32'h31);
        line(UFI_LN_SE0, 120);
        wr(12'h070, 32'h1);
        wr(12'h020, 32'hFF);
        line(UFI_LN_J, 120);
        line(UFI_LN_SE0, 120);
        rd(12'h020, rv);
        chk(rv & 32'h41, 32'h41);
        for (int r = 1; r >= 0; r--) begin
            wr(12'h070, 32'(r));
            wr(12'h020, 32'hFF);
            pulse(r ? ufi_evt_s'{stall_tx: 1'h1, sof_rx: 1'h1, default: '0}
                    : ufi_evt_s'{stall_rx: 1'h1, sof_thresh: 1'h1, default: '0});
            rd(12'h020, rv);
            chk(rv & 32'h84, 32'h0);
            pulse(r ? ufi_evt_s'{stall_rx: 1'h1, sof_thresh: 1'h1, default: '0}
                    : ufi_evt_s'{stall_tx: 1'h1, sof_rx: 1'h1, default: '0});
            rd(12'h020, rv);
            chk(rv & 32'h84, 32'h84);
        end
        wr(12'h030, 32'h8);
        pulse('{token_done: 1'h1, token_stat: 8'h5A, default: '0});
        pulse('{token_done: 1'h1, token_stat: 8'h3C, default: '0});
        irq_is(1'h1);
        rd(12'h060, rv);
        chk(rv, 32'h5A);
        wr(12'h020, 32'h8);
        rd(12'h060, rv);
        chk(rv, 32'h3C);
        wr(12'h020, 32'h8);
        rd(12'h020, rv);
        chk(rv & 32'h8, 32'h0);
        pulse('{err: 8'h04, default: '0});
        rd(12'h020, rv);
        chk(rv & 32'h2, 32'h0);
        wr(12'h040, 32'h4);
        wr(12'h020, 32'h2);
        rd(12'h020, rv);
        chk(rv & 32'h2, 32'h2);
        stop_test;
    end
    // Cut a hang short
    initial begin
        repeat (12000) @(posedge aclk);
        err_count++;
        stop_test;
    end
endmodule
`default_nettype wire
